// >>> common/pnp_card_consts.svh
`ifndef PNP_CARD_CONSTS_SVH
`define PNP_CARD_CONSTS_SVH

// Byte addresses of the Avalon-MM register words.
`define REG_STATUS 8'h00
`define REG_RES_DATA 8'h04
`define REG_WAKE 8'h08
`define REG_CSN 8'h0C
`define REG_CMD 8'h10

// Command register bit positions.
`define CMD_WAIT_KEY 0
`define CMD_STD_RESET 1
`define CMD_VENDOR_RESET 2

// Status register field positions.
`define STAT_READY 0
`define STAT_STATE_LO 2
`define STAT_CSN_LO 8

// Pointer positions: length byte at 0, identifier from 1, resource data after the 9 id bytes.
`define PTR_LEN 6'h00
`define PTR_FIRST 6'h01
`define PTR_RES_START 6'h0A
`define SHIFT_BITS 4'h8
`define SHIFT_STEP 4'h1
`define SHIFT_IDLE 4'h0
`define CSN_ZERO 8'h00
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000

`endif

// >>> common/pnp_card_pkg.sv
package pnp_card_pkg;

  typedef enum logic [1:0] {WAIT_KEY, SLEEP, ISOLATE, CONFIG} pnp_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } mcu_load_t;

endpackage

// >>> src/isa_pnp_card_state_machine.sv
// Purpose: Card-side configuration state machine, card select number and resource read path.
// Assumes: Key detection and bit-serial isolation sit outside and report by KEY_DETECTED
//          and ISO_LOSE; the microcontroller loads the SRAM through MCU_LOAD.
// Notes: Registers are reached over Avalon-MM with one wait state on every access.
//        State, number, pointers, ack and ready have a combinational next value and a plain clocked update; the shift registers do not.
//        The SRAM has no reset, so a bus reset must be followed by a fresh load.
//
// Behaviour
// RULE_01: Card has four states: wait-for-key, sleep, isolation, configuration.
// RULE_02: Bus reset goes to wait-for-key and zeroes the card select number.
// RULE_03: Wait for Key command returns any state to wait-for-key.
// RULE_04: Standard reset zeroes the number; vendor reset zeroes it on this card type.
// RULE_05: Microcontroller loads SRAM bytewise: length, identifier bytes, resource data.
// RULE_06: Resource data read returns the byte at the pointer, then increments it.
// RULE_07: Read at pointer equal to length wraps pointer to resource data start.
// RULE_08: Reset or any Wake command returns the data pointer to position one.
// RULE_09: After reset the number is zero, data is loaded, then wait-for-key.
// RULE_10: Host waits 2 ms after reset before configuration accesses.
// RULE_11: In wait-for-key the card ignores every configuration access.
// RULE_12: Detected initiation key moves wait-for-key to sleep.
// RULE_13: In sleep, Wake zero with number zero enters isolation, pointer to start.
// RULE_14: Host programs the read-data port before the first isolation reads.
// RULE_15: Host does 72 read pairs; losing cards return to sleep.
// RULE_16: Nonzero number written to isolated card is stored; card enters configuration.
// RULE_17: Wake zero sends configuration to sleep; sleeping zero-number cards isolate.
// RULE_18: Sleeping card with Wake matching its nonzero number enters configuration.
// RULE_19: Resource data is served only in configuration.
// RULE_20: After matching Wake from sleep, the first nine bytes are the identifier.
// RULE_21: Status bit 0 marks a ready byte; a read clears, shifts eight bits, sets.
// RULE_22: Host polls status bit 0 before each resource data read.
// RULE_23: A card with a nonzero number skips isolation until numbers are cleared.
// RULE_24: Wake matching neither zero nor own number sends isolation or configuration to sleep.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pnp_card_consts.svh"

module isa_pnp_card_state_machine #(
  parameter int SRAM_DEPTH = 64,
  parameter bit VENDOR_TYPE = 1'b1
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire pnp_card_pkg::mcu_load_t MCU_LOAD,
  input wire logic KEY_DETECTED,
  input wire logic ISO_LOSE
);

  localparam int PW = $clog2(SRAM_DEPTH);

  // Machine state and card select number.
  pnp_card_pkg::pnp_state_t state;
  pnp_card_pkg::pnp_state_t next_state;
  logic [7:0] csn;
  logic [7:0] next_csn;

  // Byte store and its two pointers.
  logic [7:0] sram [SRAM_DEPTH];
  logic [PW-1:0] load_addr;
  logic [PW-1:0] next_load_addr;
  logic [PW-1:0] ptr;
  logic [PW-1:0] next_ptr;
  logic [PW-1:0] len;
  logic ptr_moved;
  logic next_ptr_moved;

  // Bit-serial path into the resource data register.
  logic [7:0] fetch;
  logic [7:0] src;
  logic [7:0] res_byte;
  logic [3:0] shift_cnt;
  logic shifting;
  logic ready;
  logic next_ready;

  // Bus handshake and decoded accesses.
  logic ack;
  logic next_ack;
  logic req;
  logic take_wr;
  logic take_rd;
  logic live;
  logic in_config;
  logic sel_status;
  logic sel_res;
  logic sel_wake;
  logic sel_csn;
  logic sel_cmd;
  logic wake_wr;
  logic csn_wr;
  logic cmd_wr;
  logic res_rd;
  logic csn_take;
  logic [7:0] wr_byte;
  logic [31:0] next_readdata;

  // Decoded commands and wake values.
  logic cmd_wait_key;
  logic cmd_clear_csn;
  logic wake_zero;
  logic wake_own;
  logic wake_other;

  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign take_wr = AVS_WRITE & ack;
  assign take_rd = AVS_READ & ack;
  assign wr_byte = AVS_WRITEDATA[7:0];
  assign len = sram[`PTR_LEN][PW-1:0];
  assign live = (state != pnp_card_pkg::WAIT_KEY); // RULE_11
  assign in_config = (state == pnp_card_pkg::CONFIG); // RULE_19

  // Register select; unmapped addresses select nothing.
  always_comb begin
    sel_status = 1'b0;
    sel_res = 1'b0;
    sel_wake = 1'b0;
    sel_csn = 1'b0;
    sel_cmd = 1'b0;
    if (AVS_ADDRESS == `REG_STATUS) begin
      sel_status = 1'b1;
    end else if (AVS_ADDRESS == `REG_RES_DATA) begin
      sel_res = 1'b1;
    end else if (AVS_ADDRESS == `REG_WAKE) begin
      sel_wake = 1'b1;
    end else if (AVS_ADDRESS == `REG_CSN) begin
      sel_csn = 1'b1;
    end else if (AVS_ADDRESS == `REG_CMD) begin
      sel_cmd = 1'b1;
    end
  end

  // Writes land only at the answer edge and only once the key has been seen.
  assign wake_wr = take_wr & live & sel_wake;
  assign csn_wr = take_wr & live & sel_csn;
  assign cmd_wr = take_wr & live & sel_cmd;
  assign res_rd = take_rd & in_config & sel_res; // RULE_19
  // Only the isolated card accepts a number, and only a nonzero one.
  assign csn_take = csn_wr & (state == pnp_card_pkg::ISOLATE) & (wr_byte != `CSN_ZERO);

  // Command and wake value decode.
  always_comb begin
    cmd_wait_key = cmd_wr & wr_byte[`CMD_WAIT_KEY]; // RULE_03
    cmd_clear_csn = cmd_wr & wr_byte[`CMD_STD_RESET]; // RULE_04
    if (VENDOR_TYPE && wr_byte[`CMD_VENDOR_RESET]) begin
      cmd_clear_csn = cmd_wr; // RULE_04
    end
    wake_zero = wake_wr & (wr_byte == `CSN_ZERO);
    wake_own = wake_wr & (wr_byte != `CSN_ZERO) & (wr_byte == csn);
    wake_other = wake_wr & (wr_byte != `CSN_ZERO) & (wr_byte != csn);
  end

  // Every access gets exactly one wait state; the answer edge is the second.
  // A request held past its answer simply starts a new access one cycle later.
  always_comb begin
    next_ack = req & ~ack;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  // Read data is chosen from the state before the first edge of the access.
  // Sampling it there, not at the answer edge, keeps it standing through that edge.
  always_comb begin
    next_readdata = `WORD_ZERO;
    if (!live) begin
      next_readdata = `WORD_ZERO; // RULE_11
    end else if (sel_status) begin
      next_readdata[`STAT_READY] = ready & in_config; // RULE_21
      next_readdata[`STAT_STATE_LO +: 2] = state;
      next_readdata[`STAT_CSN_LO +: 8] = csn;
    end else if (sel_res) begin
      if (in_config) begin
        next_readdata[7:0] = res_byte; // RULE_06 RULE_19
      end
    end else if (sel_csn) begin
      next_readdata[7:0] = csn;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      AVS_READDATA <= `WORD_ZERO;
    end else if (AVS_READ & ~ack) begin
      AVS_READDATA <= next_readdata;
    end
  end

  // The microcontroller load port fills the SRAM from address zero after every reset.
  // A load beyond the last byte wraps and overwrites the length byte.
  always_comb begin
    next_load_addr = load_addr;
    if (MCU_LOAD.wr) begin
      next_load_addr = load_addr + 1'b1; // RULE_05
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      load_addr <= '0; // RULE_09
    end else begin
      load_addr <= next_load_addr;
    end
  end

  // The store itself has no reset; its contents are whatever was last loaded.
  always_ff @(posedge CLK_SYS) begin
    if (MCU_LOAD.wr) begin
      sram[load_addr] <= MCU_LOAD.data; // RULE_05
    end
  end

  // Configuration state machine: a command to wait for the key overrides everything.
  always_comb begin
    next_state = state;
    case (state) // RULE_01
      pnp_card_pkg::WAIT_KEY: begin
        if (KEY_DETECTED) begin
          next_state = pnp_card_pkg::SLEEP; // RULE_12
        end
      end
      pnp_card_pkg::SLEEP: begin
        if (wake_zero && csn == `CSN_ZERO) begin
          next_state = pnp_card_pkg::ISOLATE; // RULE_13 RULE_17 RULE_23
        end else if (wake_own) begin
          next_state = pnp_card_pkg::CONFIG; // RULE_18
        end
      end
      pnp_card_pkg::ISOLATE: begin
        // Losing isolation beats a number written in the same cycle; the card sleeps but still stores the number.
        if (ISO_LOSE) begin
          next_state = pnp_card_pkg::SLEEP; // RULE_15
        end else if (csn_take) begin
          next_state = pnp_card_pkg::CONFIG; // RULE_16
        end else if (wake_other) begin
          next_state = pnp_card_pkg::SLEEP; // RULE_24
        end
      end
      pnp_card_pkg::CONFIG: begin
        if (wake_zero || wake_other) begin
          next_state = pnp_card_pkg::SLEEP; // RULE_17 RULE_24
        end
      end
      default: begin
        next_state = pnp_card_pkg::WAIT_KEY;
      end
    endcase
    if (cmd_wait_key) begin
      next_state = pnp_card_pkg::WAIT_KEY; // RULE_03
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= pnp_card_pkg::WAIT_KEY; // RULE_02 RULE_09
    end else begin
      state <= next_state;
    end
  end

  // Card select number; the clear commands leave the state alone.
  always_comb begin
    next_csn = csn;
    if (cmd_clear_csn) begin
      next_csn = `CSN_ZERO; // RULE_04
    end else if (csn_take) begin
      next_csn = wr_byte; // RULE_16
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      csn <= `CSN_ZERO; // RULE_02 RULE_09
    end else begin
      csn <= next_csn;
    end
  end

  // Data pointer. A card reaching configuration by winning isolation starts at the
  // resource block; one woken by a matching Wake starts at the identifier.
  always_comb begin
    next_ptr = ptr;
    next_ptr_moved = 1'b0;
    if (wake_wr) begin
      next_ptr = PW'(`PTR_FIRST); // RULE_08 RULE_13 RULE_20
      next_ptr_moved = 1'b1;
    end else if (csn_take) begin
      next_ptr = PW'(`PTR_RES_START);
      next_ptr_moved = 1'b1;
    end else if (res_rd) begin
      next_ptr_moved = 1'b1;
      if (ptr == len) begin
        next_ptr = PW'(`PTR_RES_START); // RULE_07
      end else begin
        next_ptr = ptr + 1'b1; // RULE_06
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ptr <= PW'(`PTR_FIRST); // RULE_08
      ptr_moved <= 1'b1;
    end else begin
      ptr <= next_ptr;
      ptr_moved <= next_ptr_moved;
    end
  end

  // The next byte is shifted in bit 0 first over eight clocks, complete nine clocks after the pointer moves.
  // A read that lands mid-shift returns a partial byte; the host must poll first.
  assign fetch = sram[ptr];
  assign shifting = (shift_cnt != `SHIFT_IDLE);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shift_cnt <= `SHIFT_IDLE;
    end else if (ptr_moved) begin
      shift_cnt <= `SHIFT_BITS; // RULE_21
    end else if (shifting) begin
      shift_cnt <= shift_cnt - `SHIFT_STEP;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      src <= `BYTE_ZERO;
    end else if (ptr_moved) begin
      src <= fetch;
    end else if (shifting) begin
      src <= {1'b0, src[7:1]};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      res_byte <= `BYTE_ZERO;
    end else if (!ptr_moved && shifting) begin
      res_byte <= {src[0], res_byte[7:1]}; // RULE_21
    end
  end

  // A read clears the flag; it rises again on the last shift.
  always_comb begin
    next_ready = ready;
    if (res_rd | ptr_moved) begin
      next_ready = 1'b0; // RULE_21
    end else if (shift_cnt == `SHIFT_STEP) begin
      next_ready = 1'b1; // RULE_21
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ready <= 1'b0;
    end else begin
      ready <= next_ready;
    end
  end

endmodule

// >>> verif/pnp_chk.sv
// Purpose: Port assertions for the card state machine.
// Assumes: One wait state on every access.
// Notes: Ready-high timing allows two cycles of slack; the ready-low window leaves three.
`timescale 1ns/1ps
module pnp_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic KEY_DETECTED
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic locked;
  logic fresh;
  logic [3:0] cnt;
  wire rd_ack = AVS_READ && !AVS_WAITREQUEST;
  wire wr_ack = AVS_WRITE && !AVS_WAITREQUEST;
  wire st_ack = rd_ack && AVS_ADDRESS == 8'h00;
  always_ff @(posedge CLK_SYS) begin
    locked <= RST || (locked && !KEY_DETECTED);
  end
  always_ff @(posedge CLK_SYS) begin
    fresh <= !RST && !wr_ack && (fresh || (locked && KEY_DETECTED));
  end
  // Cycles since the read pointer last moved.
  always_ff @(posedge CLK_SYS) begin
    if (RST || (rd_ack && AVS_ADDRESS == 8'h04) || (wr_ack && AVS_ADDRESS[3])) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + {3'h0, cnt != 4'hF};
    end
  end
  AST_ONE_WAIT: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("wait");
  AST_RST_DATA: assert property (
    $past(RST) |-> AVS_READDATA == 32'h0000_0000) else $error("reset data");
  AST_LOCKED: assert property (
    rd_ack && locked |-> AVS_READDATA == 32'h0000_0000) else $error("locked read");
  AST_KEY_SLEEP: assert property (
    st_ack && fresh |-> AVS_READDATA[3:2] == 2'b01) else $error("key");
  AST_READY_LOW: assert property (
    st_ack && cnt inside {[2:6]} |-> !AVS_READDATA[0]) else $error("ready early");
  AST_READY_HIGH: assert property (
    st_ack && cnt > 4'hB && AVS_READDATA[3:2] == 2'b11 |-> AVS_READDATA[0]) else $error("rdy");
  AST_HOLD: assert property (
    !AVS_READ |=> $stable(AVS_READDATA)) else $error("hold");
  AST_ISO_CSN: assert property (
    st_ack && AVS_READDATA[3:2] == 2'b10 |-> AVS_READDATA[15:8] == 8'h00) else $error("csn");
endmodule

// >>> verif/host_model.sv
// Purpose: Host bus master in place of configuration software.
// Assumes: One access at a time.
// Notes: Signals change just after a rising edge.
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic rd,
  output logic wr,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic wait_req
);
  initial begin
    {rd, wr, addr, wdata} = '0;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    {rd, wr, addr, wdata} <= {~w, w, a, 24'h00_0000, d};
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    {rd, wr} <= 2'b00;
  endtask
  // Software sees the ready flag before each resource byte.
  task automatic res(output logic [31:0] q);
    do acc(1'b0, 8'h00, 8'h00, q); while (q[0] !== 1'b1);
    acc(1'b0, 8'h04, 8'h00, q);
  endtask
endmodule

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the card state machine.
// Assumes: The SRAM is loaded after reset.
// Notes: Byte 0 holds the length and byte i past it holds 8'h40 plus i, so wraps show plainly.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam logic [7:0] LEN = 8'h0D;
  logic clk_sys = 1'b0, rst = 1'b1, key = 1'b0, lose = 1'b0, rd, wr, wait_req;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  pnp_card_pkg::mcu_load_t load = '0;
  int failures = 0, n_tests = 0, cycles = 0;
  isa_pnp_card_state_machine u_dut (.CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .MCU_LOAD(load), .KEY_DETECTED(key), .ISO_LOSE(lose));
  host_model u_host (.clk(clk_sys), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
    .rdata(rdata), .wait_req(wait_req));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("mismatch %0t timeout", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic pulse(input logic k);
    @(posedge clk_sys);
    {key, lose} <= {k, ~k};
    @(posedge clk_sys);
    {key, lose} <= 2'b00;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask
  task automatic st(input logic [1:0] s, input logic [7:0] c);
    u_host.acc(1'b0, 8'h00, 8'h00, q);
    `CHK(q & 32'hFFFF_FFFE, {16'h0000, c, 4'h0, s, 2'b00})
  endtask
  task automatic reset_dut();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task automatic t_load();
    for (int i = 0; i <= LEN; i++) begin
      @(posedge clk_sys);
      load <= {1'b1, (i == 0) ? LEN : 8'h40 + 8'(i)};
      @(posedge clk_sys);
      load <= '0;
    end
  endtask
  task automatic t_lock();
    wr8(8'h08, 8'h00);
    u_host.acc(1'b0, 8'h04, 8'h00, q);
    `CHK(q, 32'h0000_0000)
    pulse(1'b1);
    st(2'd1, 8'h00);
  endtask
  task automatic t_iso_cfg();
    wr8(8'h08, 8'h00);
    st(2'd2, 8'h00);
    u_host.acc(1'b0, 8'h04, 8'h00, q);
    `CHK(q, 32'h0000_0000)
    wr8(8'h0C, 8'h05);
    st(2'd3, 8'h05);
    for (int i = 0; i < 6; i++) begin
      u_host.res(q);
      `CHK(q[7:0], 8'h4A + 8'(i % 4))
    end
  endtask
  task automatic t_wake();
    wr8(8'h08, 8'h00);
    st(2'd1, 8'h05);
    wr8(8'h08, 8'h05);
    st(2'd3, 8'h05);
    u_host.res(q);
    `CHK(q[7:0], 8'h41)
    u_host.res(q);
    `CHK(q[7:0], 8'h42)
    wr8(8'h08, 8'h07);
    st(2'd1, 8'h05);
  endtask
  task automatic t_cmds();
    wr8(8'h08, 8'h00);
    st(2'd1, 8'h05);
    wr8(8'h10, 8'h02);
    st(2'd1, 8'h00);
    wr8(8'h08, 8'h00);
    pulse(1'b0);
    st(2'd1, 8'h00);
    wr8(8'h08, 8'h00);
    wr8(8'h0C, 8'h03);
    wr8(8'h10, 8'h04);
    st(2'd3, 8'h00);
    wr8(8'h10, 8'h01);
    st(2'd0, 8'h00);
    pulse(1'b1);
    st(2'd1, 8'h00);
  endtask
  task automatic t_rst();
    wr8(8'h08, 8'h00);
    wr8(8'h0C, 8'h09);
    reset_dut();
    pulse(1'b1);
    st(2'd1, 8'h00);
    u_host.acc(1'b0, 8'h20, 8'h00, q);
    `CHK(q, 32'h0000_0000)
  endtask
  initial begin
    reset_dut();
    t_load();
    t_lock();
    t_iso_cfg();
    t_wake();
    t_cmds();
    t_rst();
    end_sim();
  end
endmodule
bind isa_pnp_card_state_machine pnp_chk u_chk (.CLK_SYS, .RST, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .KEY_DETECTED);
